// >>> common/amc_pkg.sv
// constants for the mode control register bank
// assumes a serial host on cs_b/sck/sdi/sdo and a core clock clk
package amc_pkg;
  // =====================================================
  // register addresses
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [6:0] ADDR_FORMAT_POWER = 7'h01;
  localparam logic [6:0] ADDR_OUTPUT_MODE = 7'h02;
  localparam logic [6:0] ADDR_TP_HIGH = 7'h03;
  localparam logic [6:0] ADDR_TP_LOW = 7'h04;
  // =====================================================
  // field positions
  localparam int RESET_BIT = 7;
  localparam int SLEEP_BIT = 4;
  localparam int TERM_BIT = 4;
  localparam int OUTPUT_DISABLE_BIT = 3;
  localparam int TPEN_BIT = 7;
  localparam int WORD_BITS = 16;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam logic [4:0] FRAME_LAST = 5'h0f;
  // =====================================================
  // driver current codes and serialization codes
  localparam logic [2:0] ILV_3P5 = 3'h0;
  localparam logic [2:0] ILV_UNUSED = 3'h3;
  localparam logic [2:0] SER_2L16 = 3'h0;
  localparam logic [2:0] SER_2L14 = 3'h1;
  localparam logic [2:0] SER_2L12 = 3'h2;
  localparam logic [2:0] SER_1L14 = 3'h5;
  localparam logic [2:0] SER_1L16 = 3'h6;
  localparam logic [2:0] SER_1L16B = 3'h7;
endpackage

// >>> rtl/amc_sync.sv
// two flop synchroniser for a level
// assumes d comes from another clock domain
`timescale 1ns/1ns
module amc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// >>> rtl/amc_shift.sv
// serial frame receiver on the serial clock
// assumes cs_b resets the frame asynchronously between words
`timescale 1ns/1ns
module amc_shift (
  input wire logic sck,
  input wire logic cs_b,
  input wire logic sdi,
  output logic [15:0] word,
  output logic [4:0] count
);
  // =====================================================
  // cs_b high clears the frame, so no edge is needed after it
  always_ff @(posedge sck or posedge cs_b)
  begin
    if (cs_b)
    begin
      word <= 16'h0000;
      count <= 5'h00;
    end
    else if (count < 5'h10)
    begin
      word <= {word[14:0], sdi}; // RULE_13
      count <= count + 5'h01; // RULE_14
    end
  end
endmodule

// >>> rtl/amc_regs.sv
// mode control register bank of a four channel converter
// assumes an external serial host; core logic runs on clk
// Summary of operation
// RULE_01: sleep bit disables all four channels
// RULE_02: each nap bit naps its channel
// RULE_03: three bit field selects driver current
// RULE_04: termination bit doubles the driver current; drive_ma_x4 ignores it, only internal_term_enable follows it
// RULE_05: host uses termination only at low currents
// RULE_06: output disable bit turns outputs off
// RULE_07: serialization field selects lanes and width
// RULE_08: pattern enable bit turns test pattern on
// RULE_09: high register gives pattern bits 11..6
// RULE_10: low register gives pattern bits 5..0
// RULE_11: two low bits give extra pattern bits
// RULE_12: unused high register bit is ignored
// RULE_13: word is flag, address, data, msb first
// RULE_14: only first sixteen rising edges sampled
// RULE_15: read returns register, leaves it unchanged
// RULE_16: reset bit clears all registers, sleeps briefly
// RULE_17: pattern replaces data in selected mode
// RULE_18: write lands only after whole word
`timescale 1ns/1ns
module amc_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sck,
  input wire logic cs_b,
  input wire logic sdi,
  output logic sdo_o,
  output logic sdo_oe_b,
  output logic [3:0] chan_enable,
  output logic [3:0] chan_nap,
  output logic sleep_active,
  output logic [3:0] drive_ma_x4,
  output logic internal_term_enable,
  output logic outputs_enabled,
  output logic [1:0] lane_count,
  output logic [4:0] serial_width,
  output logic mode_valid,
  output logic pattern_output_enable,
  output logic [13:0] pattern_word
);
  // =====================================================
  // link side: frame capture and readback on sck
  logic [15:0] word;
  logic [4:0] count;
  amc_shift u_shift (
    .sck(sck),
    .cs_b(cs_b),
    .sdi(sdi),
    .word(word),
    .count(count)
  );

  // readback shifts out on falling edges after the address byte
  logic [7:0] rd_shift_reg;
  logic rd_active_reg;
  logic [7:0] rd_value;
  logic [7:0] fp_reg;
  logic [7:0] om_reg;
  logic [7:0] tph_reg;
  logic [7:0] tpl_reg;
  logic [7:0] fp_link_reg;
  logic [7:0] om_link_reg;
  logic [7:0] tph_link_reg;
  logic [7:0] tpl_link_reg;

  // register copies for readback: quasi static, resync not needed
  // since the host only reads between its own writes
  always_ff @(negedge sck or posedge cs_b)
  begin
    if (cs_b)
    begin
      fp_link_reg <= 8'h00;
      om_link_reg <= 8'h00;
      tph_link_reg <= 8'h00;
      tpl_link_reg <= 8'h00;
    end
    else
    begin
      fp_link_reg <= fp_reg;
      om_link_reg <= om_reg;
      tph_link_reg <= tph_reg;
      tpl_link_reg <= tpl_reg;
    end
  end

  always_comb
  begin
    unique case (word[6:0])
      amc_pkg::ADDR_FORMAT_POWER: rd_value = fp_link_reg;
      amc_pkg::ADDR_OUTPUT_MODE: rd_value = om_link_reg;
      amc_pkg::ADDR_TP_HIGH: rd_value = tph_link_reg;
      amc_pkg::ADDR_TP_LOW: rd_value = tpl_link_reg;
      default: rd_value = amc_pkg::REG_RESET_VAL;
    endcase
  end

  always_ff @(negedge sck or posedge cs_b)
  begin
    if (cs_b)
    begin
      rd_shift_reg <= 8'h00;
      rd_active_reg <= 1'b0;
      sdo_oe_b <= 1'b1;
    end
    else if (count == 5'h08 && !rd_active_reg)
    begin
      rd_active_reg <= word[7]; // RULE_15
      rd_shift_reg <= rd_value;
      sdo_oe_b <= word[7] ? rd_value[7] : 1'b1; // RULE_15
    end
    else if (rd_active_reg)
    begin
      rd_shift_reg <= {rd_shift_reg[6:0], 1'b1};
      sdo_oe_b <= rd_shift_reg[6];
    end
  end

  // open drain: only ever pulls low; enable comes from a flop
  assign sdo_o = 1'b0;

  // =====================================================
  // crossing: frame word is stable once 16 bits are in and
  // cs_b holds it until rising; a full-frame level is synced
  logic frame_full;
  logic frame_full_s;
  logic frame_full_d_reg;
  // count[4] alone marks a full frame: one bit, so no decode glitch
  assign frame_full = count[4];
  amc_sync #(.W(1)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d(frame_full),
    .q(frame_full_s)
  );

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      frame_full_d_reg <= 1'b0;
    else
      frame_full_d_reg <= frame_full_s;
  end

  // write lands before cs_b rises; word is cleared on that rise, so capture
  // it on the synced rising level while it still stands
  logic [15:0] cap_reg;
  logic cap_valid_reg;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cap_reg <= 16'h0000;
      cap_valid_reg <= 1'b0;
    end
    else if (frame_full_s && !frame_full_d_reg)
    begin
      cap_reg <= word;
      cap_valid_reg <= 1'b1;
    end
    else
      cap_valid_reg <= 1'b0;
  end

  logic wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic sw_reset;
  assign wr_en = cap_valid_reg && !cap_reg[15]; // RULE_18 RULE_15
  assign wr_addr = cap_reg[14:8]; // RULE_13
  assign wr_data = cap_reg[7:0];
  assign sw_reset = wr_en && wr_addr == amc_pkg::ADDR_RESET
    && wr_data[amc_pkg::RESET_BIT];

  // =====================================================
  // register bank; the reset bit itself is never stored, so it
  // reads back as zero once the write is done
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fp_reg <= amc_pkg::REG_RESET_VAL;
      om_reg <= amc_pkg::REG_RESET_VAL;
      tph_reg <= amc_pkg::REG_RESET_VAL;
      tpl_reg <= amc_pkg::REG_RESET_VAL;
    end
    else if (sw_reset)
    begin
      fp_reg <= amc_pkg::REG_RESET_VAL; // RULE_16
      om_reg <= amc_pkg::REG_RESET_VAL;
      tph_reg <= amc_pkg::REG_RESET_VAL;
      tpl_reg <= amc_pkg::REG_RESET_VAL;
    end
    else if (wr_en)
    begin
      if (wr_addr == amc_pkg::ADDR_FORMAT_POWER)
        fp_reg <= wr_data; // RULE_18
      if (wr_addr == amc_pkg::ADDR_OUTPUT_MODE)
        om_reg <= wr_data;
      if (wr_addr == amc_pkg::ADDR_TP_HIGH)
        tph_reg <= {wr_data[7], 1'b0, wr_data[5:0]}; // RULE_12
      if (wr_addr == amc_pkg::ADDR_TP_LOW)
        tpl_reg <= wr_data;
    end
  end

  // momentary sleep pulse from the software reset
  logic reset_sleep_reg;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      reset_sleep_reg <= 1'b0;
    else
      reset_sleep_reg <= sw_reset; // RULE_16
  end

  // =====================================================
  // decoded controls, all registered
  logic sleep_next;
  logic [3:0] ma_x4_next;
  logic [1:0] lanes_next;
  logic [4:0] width_next;
  logic valid_next;
  assign sleep_next = fp_reg[amc_pkg::SLEEP_BIT] | reset_sleep_reg;

  always_comb
  begin
    // current in quarter milliamps; termination drives its own output and does not change it
    unique case (om_reg[7:5]) // RULE_03
      3'h0: ma_x4_next = 4'he;
      3'h1: ma_x4_next = 4'h0;
      3'h2: ma_x4_next = 4'h2;
      3'h4: ma_x4_next = 4'hc;
      3'h5: ma_x4_next = 4'ha;
      3'h6: ma_x4_next = 4'h8;
      3'h7: ma_x4_next = 4'h7;
      default: ma_x4_next = 4'h0;
    endcase
    lanes_next = 2'h2;
    width_next = 5'h10;
    valid_next = 1'b1;
    unique case (om_reg[2:0]) // RULE_07
      amc_pkg::SER_2L16: width_next = 5'h10;
      amc_pkg::SER_2L14: width_next = 5'h0e;
      amc_pkg::SER_2L12: width_next = 5'h0c;
      amc_pkg::SER_1L14:
      begin
        lanes_next = 2'h1;
        width_next = 5'h0e;
      end
      amc_pkg::SER_1L16, amc_pkg::SER_1L16B:
      begin
        lanes_next = 2'h1;
        width_next = 5'h10;
      end
      default: valid_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sleep_active <= 1'b0;
      chan_enable <= 4'h0;
      chan_nap <= 4'h0;
      drive_ma_x4 <= 4'h0;
      internal_term_enable <= 1'b0;
      outputs_enabled <= 1'b0;
      lane_count <= 2'h0;
      serial_width <= 5'h00;
      mode_valid <= 1'b0;
      pattern_output_enable <= 1'b0;
      pattern_word <= 14'h0000;
    end
    else
    begin
      sleep_active <= sleep_next; // RULE_01
      chan_enable <= sleep_next ? 4'h0 : ~fp_reg[3:0]; // RULE_01 RULE_02
      chan_nap <= sleep_next ? 4'h0 : fp_reg[3:0]; // RULE_02
      drive_ma_x4 <= ma_x4_next;
      internal_term_enable <= om_reg[amc_pkg::TERM_BIT]; // RULE_04
      outputs_enabled <= ~om_reg[amc_pkg::OUTPUT_DISABLE_BIT]; // RULE_06
      lane_count <= lanes_next;
      serial_width <= width_next;
      mode_valid <= valid_next;
      pattern_output_enable <= tph_reg[amc_pkg::TPEN_BIT]; // RULE_08 RULE_17
      pattern_word <= {tph_reg[5:0], tpl_reg[7:2], // RULE_09 RULE_10
        tpl_reg[1:0]}; // RULE_11
    end
  end

  // =====================================================
  a_sleep_all: assert property (@(posedge clk) disable iff (!rst_b) // RULE_01
    sleep_next |=> chan_enable == 4'h0 && sleep_active)
    else $error("sleep left a channel on");
  a_nap_map: assert property (@(posedge clk) disable iff (!rst_b) // RULE_02
    !sleep_next |=> chan_nap == $past(fp_reg[3:0]))
    else $error("nap bits not mapped");
  a_output_disable: assert property (@(posedge clk) disable iff (!rst_b) // RULE_06
    om_reg[3] |=> !outputs_enabled)
    else $error("outputs on while disabled");
  a_tp_bit6: assert property (@(posedge clk) disable iff (!rst_b) // RULE_12
    tph_reg[6] == 1'b0)
    else $error("unused pattern bit stored");
  a_swreset_clr: assert property (@(posedge clk) disable iff (!rst_b) // RULE_16
    sw_reset |=> fp_reg == 8'h00 && om_reg == 8'h00 && sleep_next)
    else $error("software reset incomplete");
  a_read_hold: assert property (@(posedge clk) disable iff (!rst_b) // RULE_15
    cap_valid_reg && cap_reg[15] |=> $stable(om_reg) && $stable(fp_reg))
    else $error("read changed a register");
  a_pattern: assert property (@(posedge clk) disable iff (!rst_b) // RULE_09
    ##1 pattern_word[13:8] == $past(tph_reg[5:0]))
    else $error("pattern high bits wrong");
  a_write_only: assert property (@(posedge clk) disable iff (!rst_b) // RULE_18
    !$stable(om_reg) |-> $past(sw_reset)
      || $past(wr_en) && $past(wr_addr) == amc_pkg::ADDR_OUTPUT_MODE)
    else $error("register changed without write");
endmodule

// >>> dv/amc_host.sv
// serial host model that frames words for the register bank
// assumes sdo is an open-drain wire with a pull-up beside it
`timescale 1ns/1ns
module amc_host (
  output logic sck,
  output logic cs_b,
  output logic sdi,
  input wire logic sdo
);
  // ==========================================
  // frame engine
  initial
  begin
    sck = 1'b0;
    cs_b = 1'b1;
    sdi = 1'b0;
  end
  // sck stands still between frames; sdi flips once released
  task automatic xfer(input logic [15:0] w, input int n,
    output logic [7:0] rd);
    rd = 8'h00;
    cs_b = 1'b0;
    #20;
    for (int i = 0; i < n; i++)
    begin
      sdi = (i < 16) ? w[15 - i] : ~w[0];
      #7;
      sck = 1'b1;
      if (i >= 8 && i < 16)
        rd[15 - i] = sdo;
      #8;
      sck = 1'b0;
    end
    // hold the frame open until the write has landed
    #600;
    cs_b = 1'b1;
    sdi = ~sdi;
    #100;
  endtask
endmodule

// >>> dv/adc_mode_control_registers_tb.sv
// self-checking bench for the mode control register bank
// assumes the host model drives sck, cs_b and sdi; sdo comes from the bench pull-up
`timescale 1ns/1ns
module adc_mode_control_registers_tb;
  // ==========================================
  // signals and tables
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  wire logic sck, cs_b, sdi, sdo;
  logic sdo_o, sdo_oe_b, sleep_active, internal_term_enable;
  logic outputs_enabled, mode_valid, pattern_output_enable;
  logic [3:0] chan_enable, chan_nap, drive_ma_x4;
  logic [1:0] lane_count;
  logic [4:0] serial_width;
  logic [13:0] pattern_word;
  logic [4:0] v;
  logic [2:0] k;
  logic [7:0] m;
  int miscompares = 0;
  int total_checks = 0;
  logic [4:0] pw [8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h0f,
    5'h10, 5'h1f};
  logic [3:0] drv [8] = '{4'he, 4'h0, 4'h2, 4'h0, 4'hc, 4'ha, 4'h8, 4'h7};
  logic [1:0] ln [8] = '{2'h2, 2'h2, 2'h2, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1};
  logic [4:0] sw [8] = '{5'h10, 5'h0e, 5'h0c, 5'h00, 5'h00, 5'h0e,
    5'h10, 5'h10};
  logic [7:0] ok = 8'he7;
  // open drain with pull-up
  assign sdo = sdo_oe_b ? 1'b1 : sdo_o;
  always #50 clk = ~clk;
  amc_host i_amc_host (.sck(sck), .cs_b(cs_b), .sdi(sdi), .sdo(sdo));
  amc_regs i_amc_regs (.clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b),
    .sdi(sdi), .sdo_o(sdo_o), .sdo_oe_b(sdo_oe_b),
    .chan_enable(chan_enable), .chan_nap(chan_nap),
    .sleep_active(sleep_active), .drive_ma_x4(drive_ma_x4),
    .internal_term_enable(internal_term_enable),
    .outputs_enabled(outputs_enabled), .lane_count(lane_count),
    .serial_width(serial_width), .mode_valid(mode_valid),
    .pattern_output_enable(pattern_output_enable),
    .pattern_word(pattern_word));
  // ==========================================
  // access tasks
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d,
    input int n);
    logic [7:0] rd;
    i_amc_host.xfer({1'b0, a, d}, n, rd);
    repeat (3) @(posedge clk);
    #5;
  endtask
  // read frame carries ones as data, which must not be written
  task automatic rdc(input string nm, input logic [6:0] a,
    input logic [7:0] e);
    logic [7:0] rd;
    i_amc_host.xfer({1'b1, a, 8'hff}, 16, rd);
    chk(nm, {8'h00, e}, {8'h00, rd});
  endtask
  task automatic zeros(input string t);
    chk("chan_enable", 16'h000f, chan_enable);
    chk("sleep", 16'h0000, sleep_active);
    chk("drive", 16'h000e, drive_ma_x4);
    chk("term", 16'h0000, internal_term_enable);
    chk("out_en", 16'h0001, outputs_enabled);
    chk("lanes", 16'h0002, lane_count);
    chk("width", 16'h0010, serial_width);
    chk("pat_en", 16'h0000, pattern_output_enable);
    chk("pat", 16'h0000, pattern_word);
    chk("valid", 16'h0001, mode_valid);
    chk("chan_nap", 16'h0000, chan_nap);
    $display("test %s done", t);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================
  // tests
  initial
  begin
    #2000000;
    miscompares++;
    end_of_test();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    #5 rst_b = 1'b1;
    repeat (2) @(posedge clk);
    #5;
    zeros("reset");
    for (int i = 0; i < 8; i++)
    begin
      v = pw[i];
      wr(amc_pkg::ADDR_FORMAT_POWER, {3'h0, v}, 16);
      chk("sleep", v[4], sleep_active);
      chk("chan_enable", v[4] ? 4'h0 : {~v[3:0]}, chan_enable);
      chk("chan_nap", v[4] ? 4'h0 : v[3:0], chan_nap);
    end
    $display("test power done");
    for (int i = 0; i < 8; i++)
    begin
      k = i[2:0];
      // termination only with the three lowest currents
      m = {k, k >= 3'h5, k[1], k};
      wr(amc_pkg::ADDR_OUTPUT_MODE, m, 16);
      rdc("output_mode", amc_pkg::ADDR_OUTPUT_MODE, m);
      if (k !== amc_pkg::ILV_UNUSED)
        chk("drive", drv[k], drive_ma_x4);
      chk("term", m[4], internal_term_enable);
      chk("out_en", !k[1], outputs_enabled);
      chk("valid", ok[k], mode_valid);
      if (ok[k])
        chk("lanes", ln[k], lane_count);
      if (ok[k])
        chk("width", sw[k], serial_width);
    end
    $display("test output mode done");
    wr(amc_pkg::ADDR_TP_HIGH, 8'hff, 16);
    wr(amc_pkg::ADDR_TP_LOW, 8'ha5, 16);
    chk("pat_en", 16'h0001, pattern_output_enable);
    chk("pat", 16'h3fa5, pattern_word);
    rdc("tp_high", amc_pkg::ADDR_TP_HIGH, 8'hbf);
    wr(amc_pkg::ADDR_TP_HIGH, 8'h55, 16);
    chk("pat_en", 16'h0000, pattern_output_enable);
    chk("pat", 16'h15a5, pattern_word);
    rdc("tp_low", amc_pkg::ADDR_TP_LOW, 8'ha5);
    $display("test pattern done");
    wr(amc_pkg::ADDR_OUTPUT_MODE, 8'h00, 16);
    wr(amc_pkg::ADDR_OUTPUT_MODE, 8'hff, 8);
    rdc("short", amc_pkg::ADDR_OUTPUT_MODE, 8'h00);
    wr(amc_pkg::ADDR_OUTPUT_MODE, 8'h4a, 20);
    rdc("long", amc_pkg::ADDR_OUTPUT_MODE, 8'h4a);
    wr(7'h05, 8'h5a, 16);
    rdc("unmapped", 7'h05, 8'h00);
    rdc("reset_reg", amc_pkg::ADDR_RESET, 8'h00);
    $display("test frames done");
    wr(amc_pkg::ADDR_RESET, 8'h80, 16);
    rdc("output_mode", amc_pkg::ADDR_OUTPUT_MODE, 8'h00);
    rdc("tp_low", amc_pkg::ADDR_TP_LOW, 8'h00);
    rdc("power", amc_pkg::ADDR_FORMAT_POWER, 8'h00);
    zeros("soft reset");
    end_of_test();
  end
endmodule
